/* include/fec_hdr_pkg.sv */
package fec_hdr_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_RECOV = 8'h04;
  localparam logic [7:0] OFF_LEN = 8'h08;
  localparam logic [7:0] OFF_TS = 8'h0C;
  localparam logic [7:0] OFF_SRC_ID = 8'h10;
  localparam logic [7:0] OFF_REPAIR_ID = 8'h14;
  localparam logic [7:0] OFF_BASE = 8'h18;
  localparam logic [7:0] OFF_MASK0 = 8'h1C;
  localparam logic [7:0] OFF_MASK1 = 8'h20;
  localparam logic [7:0] OFF_MASK2 = 8'h24;
  localparam logic [7:0] OFF_MASK3 = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2C;
  localparam logic [7:0] OFF_SESSION = 8'h30;
  localparam logic [7:0] OFF_QUERY = 8'h34;
  localparam logic [7:0] OFF_RX_W0 = 8'h38;
  localparam logic [7:0] OFF_RX_W2 = 8'h3C;
  localparam logic [7:0] OFF_COUNT = 8'h40;
  localparam logic [7:0] OFF_SEQ = 8'h44;
  // control word fields
  localparam int CTRL_START = 0;
  localparam int CTRL_LAYOUT = 1;
  localparam int CTRL_MLEN = 3;
  localparam int CTRL_PT = 8;
  // status word fields
  localparam int ST_BUSY = 0;
  localparam int ST_BAD = 1;
  localparam int ST_PROT = 2;
  localparam int ST_RXHDR = 3;
  // header layouts, retransmit flag then fixed-layout flag
  localparam logic [1:0] LAYOUT_MASK = 2'h0;
  localparam logic [1:0] LAYOUT_COLROW = 2'h1;
  localparam logic [1:0] LAYOUT_RETX = 2'h2;
  localparam logic [1:0] LAYOUT_BAD = 2'h3;
  // mask length selections: 15, 46 or 110 bits
  localparam logic [1:0] MLEN_15 = 2'h0;
  localparam logic [1:0] MLEN_46 = 2'h1;
  localparam logic [1:0] MLEN_110 = 2'h2;
  localparam logic [6:0] MASK_BITS_15 = 7'h0F;
  localparam logic [6:0] MASK_BITS_46 = 7'h2E;
  localparam logic [6:0] MASK_BITS_110 = 7'h6E;
  localparam logic [1:0] RTP_VERSION = 2'h2;
  localparam logic [3:0] IDX_F0 = 4'h4;
  localparam logic [3:0] IDX_LAST_RETX = 4'h5;
  localparam logic [3:0] IDX_LAST_SHORT = 4'h6;
  localparam logic [3:0] IDX_LAST_46 = 4'h7;
  localparam logic [3:0] IDX_LAST_110 = 4'h9;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {TX_IDLE, TX_SEND} tx_state_t;

  // sequence arithmetic wraps at 65536
  function automatic logic [15:0] seq_add(input logic [15:0] a, input logic [15:0] b);
    return a + b;
  endfunction

  function automatic logic [15:0] seq_diff(input logic [15:0] a, input logic [15:0] b);
    return a - b;
  endfunction

  // byte-enable merge of a write into a stored word
  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction
endpackage

/* verification/fec_link_peer.sv */
// far end of the header links: a stalling sink and a header source
module fec_link_peer (
  input wire logic clk, // bench clock
  input wire logic [31:0] tx_data, // header word out of the block
  input wire logic tx_valid, // word offered
  input wire logic tx_last, // final word of a packet
  output logic tx_ready, // sink, stalls one cycle in four
  output logic [31:0] rx_data, // header word into the block
  output logic rx_valid, // word valid
  output logic rx_last // final word of a header
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cap [64];
  int ptr = 0;
  int last_at = -1;
  logic [1:0] ph = 2'h0;
  initial begin
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = 32'h0;
  end
  // a slow sink proves that an offered word is held until taken
  assign tx_ready = (ph != 2'h2);
  // capture accepted words in arrival order
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    if (tx_valid && tx_ready) begin
      cap[ptr] <= tx_data;
      ptr <= ptr + 1;
      if (tx_last) last_at <= ptr;
    end
  end
  // one header per call; flags 11 are sent only when the bench asks
  task automatic send(input logic [31:0] w [6], input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_data <= w[i];
      rx_valid <= 1'b1;
      rx_last <= (i == n - 1);
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_last <= 1'b0;
    rx_data <= ~w[n-1]; // released lines must not look held
  endtask
endmodule // fec_link_peer

/* verification/testbench.sv */
module testbench
  import fec_hdr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, tx_valid, tx_last, tx_ready;
  logic rx_valid, rx_last, rx_ready;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, tx_data, rx_data;
  logic [33:0] got;
  logic [31:0] regs [11] = '{32'h0, 32'h25E1, 32'hBEEF, 32'h13579BDF, 32'h0A0B0C0D,
    32'h55667788, 32'h12340302, 32'h4001, 32'h12345678, 32'hCAFEF00D, 32'h0BADBEEF};
  int miscompares = 0;
  int n_compared = 0;
  always #5 clk = ~clk;
  fec_repair_host DUT (.clk(clk), .rst(rst), .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(1'b1), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(1'b1),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready));
  fec_link_peer peer (.clk(clk), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last));
  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    n_compared++;
    if (seen !== e) begin
      miscompares++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, e);
    end
  endtask
  // handshakes are sampled mid-cycle, where the readies have settled
  task automatic hs(input int sel);
    for (int n = 0; n < 3000; n++) begin
      @(negedge clk);
      got = sel == 1 ? {bresp, 32'h0} : {rresp, rdata};
      if (sel == 0 ? awready && wready : sel == 1 ? bvalid : sel == 2 ? arready : rvalid) begin
        @(posedge clk);
        return;
      end
    end
    miscompares++;
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    hs(0);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    hs(1);
    chk(32'(got[33:32]), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    araddr <= a;
    arvalid <= 1'b1;
    hs(2);
    arvalid <= 1'b0;
    hs(3);
    d = got[31:0];
    chk(32'(got[33:32]), 32'(er));
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, RESP_OKAY, d);
    chk(d, e);
  endtask
  // reset values and an unmapped place
  task automatic regs_basic;
    logic [31:0] d;
    rdc(OFF_STATUS, 32'h0);
    rdc(OFF_COUNT, 32'h0);
    rd(8'h48, RESP_SLVERR, d);
    chk(d, 32'h0);
    wr(8'h48, 32'h1, RESP_SLVERR);
  endtask
  // every layout but flags 11, and every mask length; seq starts at the top so it wraps
  task automatic tx_pkts;
    logic [1:0] lay [5] = '{LAYOUT_MASK, LAYOUT_MASK, LAYOUT_MASK, LAYOUT_COLROW, LAYOUT_RETX};
    logic [1:0] ml [5] = '{MLEN_15, MLEN_46, MLEN_110, MLEN_15, MLEN_15};
    int len [5] = '{7, 8, 10, 7, 6};
    int b;
    int f;
    for (int i = 1; i < 11; i++) wr(8'(i * 4), regs[i], RESP_OKAY);
    wr(OFF_SEQ, 32'hFFFF, RESP_OKAY);
    for (int p = 0; p < 5; p++) begin
      b = peer.ptr;
      f = lay[p] == LAYOUT_RETX ? 3 : 4; // no contributor word before the flags in a retransmission
      wr(OFF_CTRL, {17'h0, 7'h60, 3'h0, ml[p], lay[p], 1'b1}, RESP_OKAY);
      for (int n = 0; n < 200 && peer.ptr < b + len[p]; n++) @(posedge clk);
      @(posedge clk);
      chk({16'(peer.ptr - b), 16'(peer.last_at - b)}, {16'(len[p]), 16'(len[p] - 1)});
      chk(peer.cap[b], {RTP_VERSION, 2'h0, (lay[p] == LAYOUT_RETX ? 4'h0 : 4'h1), 1'b0,
        7'h60, 16'(32'hFFFF + p)});
      chk(peer.cap[b + 2], regs[5]);
      if (f == 4) chk(peer.cap[b + 3], regs[4]);
      chk(peer.cap[b + f], {lay[p], regs[1][13:0], regs[2][15:0]});
      chk(peer.cap[b + f + 1], regs[3]);
      chk(peer.cap[b + f + 2], lay[p] == LAYOUT_RETX ? regs[4] : lay[p] == LAYOUT_COLROW ?
        regs[6] : {regs[6][15:0], ml[p] != MLEN_15, regs[7][14:0]});
      if (len[p] > 7) chk(peer.cap[b + 7], {ml[p] == MLEN_110, regs[8][30:0]});
      if (len[p] > 8) chk(peer.cap[b + 8], regs[9]);
      if (len[p] > 8) chk(peer.cap[b + 9], regs[10]);
    end
    rdc(OFF_STATUS, 32'h0);
  endtask
  // flags 11 never leave; the fault sticks until written back
  task automatic tx_bad;
    int b;
    b = peer.ptr;
    wr(OFF_CTRL, {17'h0, 7'h60, 5'h0, LAYOUT_BAD, 1'b1}, RESP_OKAY);
    repeat (20) @(posedge clk);
    chk(32'(peer.ptr - b), 32'h0);
    rdc(OFF_STATUS, 32'h2);
    wr(OFF_STATUS, 32'h2, RESP_OKAY);
    rdc(OFF_STATUS, 32'h0);
  endtask
  // received headers: a discard, a wrapped mask member, a column stride
  task automatic rx_hdrs;
    logic [31:0] w [6];
    w = '{32'hC0000010, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0};
    peer.send(w, 3);
    repeat (2) @(posedge clk);
    rdc(OFF_COUNT, 32'h00010000);
    w[0] = 32'h00000010;
    w[2] = {16'hFFFE, 1'b0, 15'h0800}; // only offset 3 is covered
    peer.send(w, 3);
    repeat (2) @(posedge clk);
    wr(OFF_QUERY, 32'h0001, RESP_OKAY);
    rdc(OFF_STATUS, 32'hC);
    wr(OFF_QUERY, 32'h0000, RESP_OKAY);
    rdc(OFF_STATUS, 32'h8);
    w[0] = 32'h40000010;
    w[2] = 32'h01000302; // stride three over two rows
    peer.send(w, 3);
    repeat (2) @(posedge clk);
    wr(OFF_QUERY, 32'h0103, RESP_OKAY);
    rdc(OFF_STATUS, 32'hC);
    wr(OFF_QUERY, 32'h0101, RESP_OKAY);
    rdc(OFF_STATUS, 32'h8);
    wr(OFF_SESSION, 32'h0204, RESP_OKAY); // session rows 2, columns 4
    w[2] = 32'h01000000; // zero counts defer to the session
    peer.send(w, 3);
    repeat (2) @(posedge clk);
    wr(OFF_QUERY, 32'h0108, RESP_OKAY);
    rdc(OFF_STATUS, 32'hC);
    w[2] = 32'h01000400; // four columns, rows only
    peer.send(w, 3);
    repeat (2) @(posedge clk);
    rdc(OFF_STATUS, 32'h8);
    wr(OFF_QUERY, 32'h0104, RESP_OKAY);
    rdc(OFF_STATUS, 32'hC);
    wr(OFF_COUNT, 32'h0, RESP_OKAY);
    rdc(OFF_COUNT, 32'h00010004);
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    regs_basic();
    tx_pkts();
    tx_bad();
    rx_hdrs();
    summarize();
  end
endmodule // testbench

/* verilog/fec_member_check.sv */
// decides whether a queried sequence number is covered by a received header
module fec_member_check
  import fec_hdr_pkg::*;
(
  input wire logic [1:0] layout, // received flag pair
  input wire logic k0, // first continuation bit
  input wire logic k1, // second continuation bit
  input wire logic [15:0] base, // first_protected_seqnum
  input wire logic [109:0] mask, // bit 109 is offset 0
  input wire logic [7:0] col, // column count
  input wire logic [7:0] row, // row count
  input wire logic [7:0] sess_col, // session column count
  input wire logic [7:0] sess_row, // session row count
  input wire logic [15:0] retx_seq, // sequence of a retransmission
  input wire logic [15:0] query, // sequence number asked about
  output logic hit // query is protected
);
  logic [15:0] off;
  logic [7:0] eff_col;
  logic [7:0] eff_row;
  logic [6:0] mlen;
  logic mask_hit;
  logic grid_hit;

  // offsets wrap, so a base just below 65535 still covers 0, 1, ...
  assign off = seq_diff(query, base); // RL24 RL9
  // both counts zero defer to the session configuration
  assign eff_col = (col == 8'h00 && row == 8'h00) ? sess_col : col; // RL14
  assign eff_row = (col == 8'h00 && row == 8'h00) ? sess_row : row; // RL14
  assign mlen = !k0 ? MASK_BITS_15 : (!k1 ? MASK_BITS_46 : MASK_BITS_110); // RL11
  assign mask_hit = (off < {9'h000, mlen}) && mask[7'd109 - off[6:0]]; // RL10
  // rows cover base..base+L; deeper grids step by the column count
  always_comb begin
    grid_hit = 1'b0;
    if (eff_col != 8'h00) begin
      if (eff_row <= 8'h01) begin
        grid_hit = off <= {8'h00, eff_col}; // RL15 RL16
      end else begin
        grid_hit = (off % {8'h00, eff_col} == 16'h0000) &&
                   (off / {8'h00, eff_col} <= {8'h00, eff_row}); // RL17
      end
    end
  end

  assign hit = (layout == LAYOUT_MASK) ? mask_hit :
               (layout == LAYOUT_COLROW) ? grid_hit :
               (layout == LAYOUT_RETX) ? (query == retx_seq) : 1'b0; // RL2 RL13 RL18
endmodule // fec_member_check

/* verilog/fec_repair_host.sv */
// Function
// [RL1] two leading flags pick layout: 00 bitmask, 01 column/row, 10 retransmit
// [RL2] flags 11 are never sent; received 11 headers are silently dropped
// [RL3] retransmit flag is one only for retransmissions, zero for parity repairs
// [RL4] fixed-layout flag is forced zero whenever retransmit flag is one
// [RL5] header carries copies of padding, extension, count, marker, payload type
// [RL6] 16-bit length copy counts octets after the fixed 12-byte base header
// [RL7] 32-bit timestamp copy follows the length copy
// [RL8] each contributor entry names a stream; one base/mask block per stream
// [RL9] base is the lowest protected sequence number, wrap aware
// [RL10] mask bit j marks base plus j; bit zero is the most significant
// [RL11] continuation bits give mask lengths of 15, 46 or 110 bits
// [RL12] repair payload covers everything after the fixed 12-byte base header
// [RL13] column/row layout puts base, column and row counts in place of masks
// [RL14] zero column and zero row counts mean use session values
// [RL15] nonzero columns, zero rows: row protection only, no column repairs
// [RL16] row count one: row repairs first, then column repairs at column stride
// [RL17] row count above one: column protection at stride of column count
// [RL18] retransmit: sequence replaces length copy, source id in header
// [RL19] retransmitter uses a distinct repair stream id per source stream
// [RL20] retransmission is a fresh RTP header before the unchanged source packet
// [RL21] every packet uses protocol version two
// [RL22] outer marker bit is sent as zero and ignored on receipt
// [RL23] each repair packet sequence number is one above the previous one
// [RL24] sequence additions and comparisons wrap modulo 65536
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
module fec_repair_host
  import fec_hdr_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // asynchronous reset, active high
  input wire logic ce, // clock enable, freezes state when low
  input wire logic [ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte enables
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic [31:0] tx_data, // outgoing header word
  output logic tx_valid, // outgoing word valid
  output logic tx_last, // last header word of a packet
  input wire logic tx_ready, // sink takes the word
  input wire logic [31:0] rx_data, // received repair header word
  input wire logic rx_valid, // received word valid
  input wire logic rx_last, // last received header word
  output logic rx_ready // receive side takes words
);
  // the register map needs a full byte of address
  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  tx_state_t state;
  logic [31:0] ctrl, recov, len, ts, src_id, repair_id, base, mask0, mask1, mask2, mask3;
  logic [31:0] session, query, rx_w0, rx_w2, rx_w3, rx_w4, rx_w5;
  logic [15:0] out_seq, discard_cnt, accept_cnt;
  logic [31:0] tx_time, free_time, word, rd_mux;
  logic [3:0] tx_idx, slot, next_slot, last_idx, rx_idx;
  logic bad_flag, rx_hdr, hit;

  // bus decode; config other than session and query is frozen while a header is going out
  wire wr_go = ce && awvalid && wvalid && !bvalid;
  wire rd_go = ce && arvalid && !rvalid;
  wire [7:0] wa = {awaddr[7:2], 2'b00};
  wire [7:0] ra = {araddr[7:2], 2'b00};
  // address bits above the byte map make the access an error
  wire wa_mapped = (wa <= OFF_SEQ) && ((awaddr >> 8) == '0);
  wire ra_mapped = (ra <= OFF_SEQ) && ((araddr >> 8) == '0);
  wire [31:0] seq_merged = apply_strb({16'h0000, out_seq}, wdata, wstrb);
  wire busy = (state == TX_SEND);
  wire cfg_we = wr_go && !busy;
  wire start_req = cfg_we && wa == OFF_CTRL && wstrb[0] && wdata[CTRL_START];
  wire [1:0] req_layout = wdata[CTRL_LAYOUT +: 2];
  wire start_ok = start_req && req_layout != LAYOUT_BAD; // RL2
  wire bad_set = start_req && req_layout == LAYOUT_BAD; // RL2
  wire bad_clr = wr_go && wa == OFF_STATUS && wstrb[0] && wdata[ST_BAD];
  wire [1:0] layout = ctrl[CTRL_LAYOUT +: 2];
  wire [1:0] mlen = ctrl[CTRL_MLEN +: 2];
  wire retx = (layout == LAYOUT_RETX); // RL3
  wire f_bit = !retx && layout == LAYOUT_COLROW; // RL4 RL1
  wire k0 = (mlen != MLEN_15); // RL11
  wire k1 = (mlen == MLEN_110); // RL11
  wire tx_fire = ce && tx_valid && tx_ready;
  wire pkt_end = tx_fire && tx_last;
  wire rx_fire = ce && rx_valid;
  wire [31:0] rx_w0_now = (rx_idx == 4'h0) ? rx_data : rx_w0;
  wire rx_bad = rx_w0_now[31] && rx_w0_now[30]; // RL2

  assign awready = wr_go;
  assign wready = wr_go;
  assign arready = rd_go;
  assign rx_ready = ce;

  // retransmissions skip the contributor word, so later slots shift by one
  function automatic logic [3:0] slot_of(input logic [3:0] i, input logic r);
    return (r && i >= 4'h3) ? i + 4'h1 : i;
  endfunction
  assign slot = slot_of(tx_idx, retx);
  assign next_slot = slot_of(tx_idx + 4'h1, retx);
  assign last_idx = retx ? IDX_LAST_RETX : (layout == LAYOUT_COLROW || mlen == MLEN_15) ?
                    IDX_LAST_SHORT : (mlen == MLEN_46) ? IDX_LAST_46 : IDX_LAST_110;

  // header word for the slot about to be shown
  function automatic logic [31:0] hdr_word(input logic [3:0] s);
    case (s)
      4'h0: hdr_word = {RTP_VERSION, 2'b00, retx ? 4'h0 : 4'h1, 1'b0, ctrl[CTRL_PT +: 7],
                        out_seq}; // RL21 RL22 RL20 RL8 RL23
      4'h1: hdr_word = tx_time;
      4'h2: hdr_word = repair_id; // RL19
      4'h3: hdr_word = src_id; // RL8
      4'h4: hdr_word = {retx, f_bit, recov[13], recov[12], recov[11:8], recov[7], recov[6:0],
                        len[15:0]}; // RL1 RL3 RL4 RL5 RL6 RL18
      4'h5: hdr_word = ts; // RL7
      4'h6: hdr_word = retx ? src_id : (layout == LAYOUT_COLROW) ? base :
                       {base[15:0], k0, mask0[14:0]}; // RL18 RL13 RL9 RL10 RL11
      4'h7: hdr_word = {k1, mask1[30:0]}; // RL11
      4'h8: hdr_word = mask2;
      4'h9: hdr_word = mask3;
      default: hdr_word = 32'h0000_0000;
    endcase
  endfunction

  // only the header leaves here; the repair payload follows it outside (RL12)
  // a process, so the word follows register changes and not only the slot
  always_comb begin
    word = hdr_word(next_slot); // RL12
  end

  // write-side handshake; the response follows the accepted pair by one edge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (wr_go) begin
        bvalid <= 1'b1;
        bresp <= wa_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {ctrl, recov, len, ts, src_id, repair_id} <= '0;
      {base, mask0, mask1, mask2, mask3, session, query} <= '0;
    end else if (ce) begin
      if (cfg_we && wa == OFF_CTRL) ctrl <= apply_strb(ctrl, wdata, wstrb) & 32'hFFFF_FFFE;
      if (cfg_we && wa == OFF_RECOV) recov <= apply_strb(recov, wdata, wstrb);
      if (cfg_we && wa == OFF_LEN) len <= apply_strb(len, wdata, wstrb);
      if (cfg_we && wa == OFF_TS) ts <= apply_strb(ts, wdata, wstrb);
      if (cfg_we && wa == OFF_SRC_ID) src_id <= apply_strb(src_id, wdata, wstrb);
      if (cfg_we && wa == OFF_REPAIR_ID) repair_id <= apply_strb(repair_id, wdata, wstrb);
      if (cfg_we && wa == OFF_BASE) base <= apply_strb(base, wdata, wstrb);
      if (cfg_we && wa == OFF_MASK0) mask0 <= apply_strb(mask0, wdata, wstrb);
      if (cfg_we && wa == OFF_MASK1) mask1 <= apply_strb(mask1, wdata, wstrb);
      if (cfg_we && wa == OFF_MASK2) mask2 <= apply_strb(mask2, wdata, wstrb);
      if (cfg_we && wa == OFF_MASK3) mask3 <= apply_strb(mask3, wdata, wstrb);
      if (wr_go && wa == OFF_SESSION) session <= apply_strb(session, wdata, wstrb);
      if (wr_go && wa == OFF_QUERY) query <= apply_strb(query, wdata, wstrb);
    end
  end

  // sticky refusal flag: a new refusal in the clearing cycle wins
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bad_flag <= 1'b0;
    end else if (ce) begin
      bad_flag <= bad_set | (bad_flag & ~bad_clr); // RL2
    end
  end

  // transmit sequencer; tx_data always holds the word for tx_idx
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= TX_IDLE;
      tx_idx <= 4'h0;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_data <= 32'h0000_0000;
      tx_time <= 32'h0000_0000;
    end else if (ce) begin
      case (state)
        TX_IDLE: begin
          if (start_ok) begin
            state <= TX_SEND;
            tx_idx <= 4'h0;
            tx_valid <= 1'b1;
            tx_last <= 1'b0;
            tx_time <= free_time;
            tx_data <= {RTP_VERSION, 2'b00, req_layout == LAYOUT_RETX ? 4'h0 : 4'h1, 1'b0,
                        wdata[CTRL_PT +: 7], out_seq}; // RL21 RL22
          end
        end
        TX_SEND: begin
          if (tx_fire) begin
            if (tx_last) begin
              state <= TX_IDLE;
              tx_valid <= 1'b0;
              tx_last <= 1'b0;
            end else begin
              tx_idx <= tx_idx + 4'h1;
              tx_last <= (tx_idx + 4'h1 == last_idx);
              tx_data <= word;
            end
          end
        end
        default: state <= TX_IDLE;
      endcase
    end
  end

  // outer sequence steps by one per finished repair packet, wrapping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_seq <= 16'h0000;
      free_time <= 32'h0000_0000;
    end else if (ce) begin
      free_time <= free_time + 32'h0000_0001;
      if (pkt_end) begin
        out_seq <= seq_add(out_seq, 16'h0001); // RL23 RL24
      end else if (cfg_we && wa == OFF_SEQ) begin
        out_seq <= seq_merged[15:0];
      end
    end
  end

  // receive parser: latch header words, classify at the last one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_idx <= 4'h0;
      {rx_w0, rx_w2, rx_w3, rx_w4, rx_w5} <= '0;
      {discard_cnt, accept_cnt} <= '0;
      rx_hdr <= 1'b0;
    end else if (rx_fire) begin
      rx_idx <= rx_last ? 4'h0 : (rx_idx == 4'hF ? rx_idx : rx_idx + 4'h1);
      if (rx_idx == 4'h0) rx_w0 <= rx_data;
      if (rx_idx == 4'h2) rx_w2 <= rx_data;
      if (rx_idx == 4'h3) rx_w3 <= rx_data;
      if (rx_idx == 4'h4) rx_w4 <= rx_data;
      if (rx_idx == 4'h5) rx_w5 <= rx_data;
      if (rx_last && rx_bad) begin
        discard_cnt <= discard_cnt + 16'h0001; // RL2
        rx_hdr <= 1'b0;
      end else if (rx_last) begin
        accept_cnt <= accept_cnt + 16'h0001;
        rx_hdr <= 1'b1;
      end
    end
  end

  fec_member_check u_member (
    .layout(rx_w0[31:30]),
    .k0(rx_w2[15]),
    .k1(rx_w3[31]),
    .base(rx_w2[31:16]),
    .mask({rx_w2[14:0], rx_w3[30:0], rx_w4, rx_w5}),
    .col(rx_w2[15:8]),
    .row(rx_w2[7:0]),
    .sess_col(session[7:0]),
    .sess_row(session[15:8]),
    .retx_seq(rx_w0[15:0]),
    .query(query[15:0]),
    .hit(hit)
  );

  // read mux decodes the low byte only; unmapped words in the byte map read zero, words above it alias their low-byte word, all with an error response
  always_comb begin
    case (ra)
      OFF_CTRL: rd_mux = ctrl;
      OFF_RECOV: rd_mux = recov;
      OFF_LEN: rd_mux = len;
      OFF_TS: rd_mux = ts;
      OFF_SRC_ID: rd_mux = src_id;
      OFF_REPAIR_ID: rd_mux = repair_id;
      OFF_BASE: rd_mux = base;
      OFF_MASK0: rd_mux = mask0;
      OFF_MASK1: rd_mux = mask1;
      OFF_MASK2: rd_mux = mask2;
      OFF_MASK3: rd_mux = mask3;
      OFF_STATUS: rd_mux = {28'h0000000, rx_hdr, hit && rx_hdr, bad_flag, busy};
      OFF_SESSION: rd_mux = session;
      OFF_QUERY: rd_mux = query;
      OFF_RX_W0: rd_mux = rx_w0;
      OFF_RX_W2: rd_mux = rx_w2;
      OFF_COUNT: rd_mux = {discard_cnt, accept_cnt};
      OFF_SEQ: rd_mux = {16'h0000, out_seq};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // read data channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ce) begin
      if (rd_go) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= ra_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_first_word;
    ce && tx_valid && tx_idx == 4'h0;
  endsequence
  sequence s_flag_word;
    ce && tx_valid && slot == IDX_F0;
  endsequence

  a_version_two: assert property (s_first_word |-> tx_data[31:30] == 2'b10) // RL21
    else $error("outer version is not two");
  a_marker_zero: assert property (s_first_word |-> !tx_data[23]) // RL22
    else $error("outer marker bit set");
  a_no_both_flags: assert property (s_flag_word |-> !(tx_data[31] && tx_data[30])) // RL2
    else $error("header sent with both flags set");
  a_layout_flags: assert property (s_flag_word |-> tx_data[31:30] == layout) // RL1 RL3 RL4
    else $error("flag pair does not match the layout");
  a_bad_refused: assert property (bad_set && !busy |=> !busy && bad_flag) // RL2
    else $error("invalid layout was not refused");
  a_seq_step: assert property (pkt_end |=> out_seq == seq_add($past(out_seq), 16'h0001)) // RL23
    else $error("repair sequence did not step by one");
  a_ts_follows: assert property (ce && tx_valid && slot == 4'h5 |-> tx_data == ts) // RL7
    else $error("timestamp copy not after length copy");
  a_kbit_short: assert property (ce && tx_valid && slot == 4'h6 && layout == LAYOUT_MASK &&
                                 mlen == MLEN_15 |-> !tx_data[15]) // RL11
    else $error("continuation bit set on short mask");
  a_tx_hold: assert property (tx_valid && !(ce && tx_ready) |=> tx_valid && $stable(tx_data))
    else $error("header word changed before it was taken");
  a_rx_discard: assert property (rx_fire && rx_last && rx_bad |=>
                                 discard_cnt == $past(discard_cnt) + 16'h0001 && !rx_hdr) // RL2
    else $error("invalid received header not discarded");
endmodule // fec_repair_host
